// File: hrx_cfg.svh
// constants for the hex record receiver and checksum block
// assumes a single clock domain and byte-wide streams
`ifndef HRX_CFG_SVH
`define HRX_CFG_SVH
`define HRX_START     8'h3a
`define HRX_T_DATA    8'h00
`define HRX_T_END     8'h01
`define HRX_T_EXT     8'h02
`define HRX_EXT_LEN   8'h02
`define HRX_END_LEN   8'h00
`define HRX_EXT_OFF   16'h0000
`define HRX_SEG_MAX   16'h2000
`define HRX_CMD_ERASE 8'hf0
`define HRX_CMD_WRITE 8'h30
`define HRX_CMD_SUM   8'h90
`define HRX_CMD_READ  8'h40
`define HRX_CMD_ID    8'hc0
`define HRX_CMD_STAT  8'hc3
`define HRX_FLASH_LO  16'h1000
`define HRX_FLASH_HI  16'hffff
`define HRX_ID_FIRST  8'h09
`define HRX_ID_LAST   8'h12
`define HRX_ST_FIRST  8'h09
`define HRX_ST_LAST   8'h0c
`define HRX_SUM_RST   16'h0000
`endif

// File: hrx_ctrl_model.sv
// stand-in for the programming controller and the flash array behind the receiver
// assumes the bench preloads mem at time zero and calls send_byte to feed bytes
`timescale 1ns/1ps
module hrx_ctrl_model
(
    input  wire logic        clk,
    input  wire logic [15:0] mem_addr,
    input  wire logic        wr_valid,
    input  wire logic [19:0] wr_addr,
    input  wire logic [7:0]  wr_data,
    output logic             rx_valid,
    output logic      [7:0]  rx_data,
    output logic      [7:0]  mem_rdata
);
    logic [7:0] mem [0:65535];

    initial
    begin
        rx_valid  = 1'b0;
        rx_data   = 8'h00;
        mem_rdata = 8'h00;
    end

    // synchronous read: data for an address arrives one cycle later
    always @(posedge clk)
    begin
        mem_rdata <= mem[mem_addr];
        if (wr_valid === 1'b1)
            mem[wr_addr[15:0]] <= wr_data;
    end

    // one byte per pulse; released data line shows the inverse, never a stale copy
    task automatic send_byte(input logic [7:0] b);
        @(posedge clk);
        #5;
        rx_valid = 1'b1;
        rx_data  = b;
        @(posedge clk);
        #5;
        rx_valid = 1'b0;
        rx_data  = ~b;
    endtask : send_byte
endmodule : hrx_ctrl_model

// File: hrx_pkg.sv
// types shared by the hex record receiver
// assumes nothing outside itself
package hrx_pkg;
    typedef enum logic [3:0] {
        P_WAIT = 4'b0000,
        P_LEN  = 4'b0001,
        P_OFFH = 4'b0011,
        P_OFFL = 4'b0010,
        P_TYPE = 4'b0110,
        P_DATA = 4'b0111,
        P_CSUM = 4'b0101,
        P_DONE = 4'b0100,
        P_IDLE = 4'b1100
    } hrx_pstate_e;
    typedef enum logic [1:0] {
        SC_IDLE = 2'b00,
        SC_RUN  = 2'b01,
        SC_TAIL = 2'b11
    } hrx_scan_e;
endpackage : hrx_pkg

// File: hrx_receiver_checksum.sv
// hex record receiver and 16-bit byte-sum checksum engine
// assumes rx bytes come from a uart on clk, flash reads take one cycle
`timescale 1ns/1ps
`include "hrx_cfg.svh"
module hrx_receiver_checksum
    import hrx_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cmd_start,
    input  wire logic [7:0]  cmd_code,
    input  wire logic        erase_chip,
    input  wire logic [15:0] region_lo,
    input  wire logic [15:0] region_hi,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_error,
    input  wire logic        resp_valid,
    input  wire logic [7:0]  resp_byte,
    input  wire logic [7:0]  mem_rdata,
    output logic      [15:0] mem_addr,
    output logic             wr_valid,
    output logic      [19:0] wr_addr,
    output logic      [7:0]  wr_data,
    output logic             fmt_error,
    output logic             rx_idle,
    output logic             sum_done,
    output logic      [7:0]  sum_hi,
    output logic      [7:0]  sum_lo
);
    hrx_pstate_e pstate;
    hrx_pstate_e next_pstate;
    logic [7:0]  len;
    logic [7:0]  next_len;
    logic [7:0]  cnt;
    logic [7:0]  next_cnt;
    logic [7:0]  csum;
    logic [7:0]  next_csum;
    logic [15:0] off;
    logic [15:0] next_off;
    logic [15:0] seg;
    logic [15:0] next_seg;
    logic        seg_bad;
    logic        next_seg_bad;
    logic [7:0]  rtype;
    logic [7:0]  next_rtype;
    logic [19:0] next_wr_addr;
    logic        next_wr_valid;
    logic [7:0]  next_wr_data;
    logic        next_fmt_error;
    logic        end_ok;
    logic        rx_ok;

    hrx_scan_e   scan;
    hrx_scan_e   next_scan;
    logic [15:0] next_mem_addr;
    logic [15:0] scan_end;
    logic [15:0] next_scan_end;
    logic        rd_pend;
    logic        next_rd_pend;
    logic [15:0] sum;
    logic [15:0] next_sum;
    logic [7:0]  resp_idx;
    logic [7:0]  next_resp_idx;
    logic [7:0]  win_first;
    logic [7:0]  next_win_first;
    logic [7:0]  win_last;
    logic [7:0]  next_win_last;
    logic        next_sum_done;
    logic        resp_add;
    logic [7:0]  idx1;

    function automatic logic sums_cmd(input logic [7:0] c);
        sums_cmd = (c == `HRX_CMD_ERASE) || (c == `HRX_CMD_WRITE) ||
                   (c == `HRX_CMD_SUM) || (c == `HRX_CMD_READ) ||
                   (c == `HRX_CMD_ID) || (c == `HRX_CMD_STAT);
    endfunction : sums_cmd

    assign rx_ok = rx_valid && !rx_error;

    // record parser
    always_comb
    begin
        next_pstate    = pstate;
        next_len       = len;
        next_cnt       = cnt;
        next_csum      = csum;
        next_off       = off;
        next_seg       = seg;
        next_seg_bad   = seg_bad;
        next_rtype     = rtype;
        next_wr_addr   = wr_addr;
        next_wr_valid  = 1'b0;
        next_wr_data   = wr_data;
        next_fmt_error = fmt_error;
        end_ok         = 1'b0;
        if (cmd_start)
        begin
            if (cmd_code == `HRX_CMD_WRITE)
            begin
                // receive error in the same cycle still parks: set wins over clear
                next_pstate    = rx_error ? P_IDLE : P_WAIT;
                next_seg       = 16'h0000;
                next_seg_bad   = 1'b0;
                next_fmt_error = rx_error;
            end
        end
        else if (rx_error && pstate != P_IDLE && pstate != P_DONE)
        begin
            next_pstate    = P_IDLE;
            next_fmt_error = 1'b1;
        end
        else if (rx_ok)
        begin
            next_csum = csum + rx_data;
            unique case (pstate)
                P_WAIT:
                begin
                    // anything but the mark is dropped
                    if (rx_data == `HRX_START)
                    begin
                        next_pstate = P_LEN;
                        next_csum   = 8'h00;
                    end
                end
                P_LEN:
                begin
                    next_len    = rx_data;
                    next_pstate = P_OFFH;
                end
                P_OFFH:
                begin
                    next_off    = {rx_data, 8'h00};
                    next_pstate = P_OFFL;
                end
                P_OFFL:
                begin
                    next_off    = {off[15:8], rx_data};
                    next_pstate = P_TYPE;
                end
                P_TYPE:
                begin
                    next_rtype   = rx_data;
                    next_cnt     = len;
                    next_wr_addr = {seg, 4'h0} + {4'h0, off};
                    next_pstate  = (len == 8'h00) ? P_CSUM : P_DATA;
                    if ((rx_data != `HRX_T_DATA && rx_data != `HRX_T_END &&
                         rx_data != `HRX_T_EXT) ||
                        (rx_data == `HRX_T_EXT && len != `HRX_EXT_LEN) ||
                        (rx_data == `HRX_T_EXT && off != `HRX_EXT_OFF) ||
                        (rx_data == `HRX_T_END && len != `HRX_END_LEN) ||
                        (rx_data == `HRX_T_DATA && (seg_bad || len == 8'h00)))
                    begin
                        next_pstate    = P_IDLE;
                        next_fmt_error = 1'b1;
                    end
                end
                P_DATA:
                begin
                    if (rtype == `HRX_T_DATA)
                    begin
                        next_wr_valid = 1'b1;
                        next_wr_data  = rx_data;
                        if (cnt != len)
                            next_wr_addr = wr_addr + 20'h00001;
                    end
                    else
                        next_seg = {seg[7:0], rx_data};
                    next_cnt = cnt - 8'h01;
                    if (cnt == 8'h01)
                        next_pstate = P_CSUM;
                end
                P_CSUM:
                begin
                    if (next_csum != 8'h00)
                    begin
                        next_pstate    = P_IDLE;
                        next_fmt_error = 1'b1;
                    end
                    else if (rtype == `HRX_T_END)
                    begin
                        next_pstate = P_DONE;
                        end_ok      = 1'b1;
                    end
                    else
                    begin
                        if (rtype == `HRX_T_EXT)
                            next_seg_bad = seg > `HRX_SEG_MAX;
                        next_pstate = P_WAIT;
                    end
                end
                // reply pending, controller holds off
                P_DONE: next_pstate = P_DONE;
                P_IDLE: next_pstate = P_IDLE;
            endcase
        end
        if (pstate == P_DONE && sum_done)
            next_pstate = P_IDLE;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pstate    <= P_IDLE;
            len       <= 8'h00;
            cnt       <= 8'h00;
            csum      <= 8'h00;
            off       <= 16'h0000;
            seg       <= 16'h0000;
            seg_bad   <= 1'b0;
            rtype     <= 8'h00;
            wr_addr   <= 20'h00000;
            wr_valid  <= 1'b0;
            wr_data   <= 8'h00;
            fmt_error <= 1'b0;
            rx_idle   <= 1'b1;
        end
        else
        begin
            pstate    <= next_pstate;
            len       <= next_len;
            cnt       <= next_cnt;
            csum      <= next_csum;
            off       <= next_off;
            seg       <= next_seg;
            seg_bad   <= next_seg_bad;
            rtype     <= next_rtype;
            wr_addr   <= next_wr_addr;
            wr_valid  <= next_wr_valid;
            wr_data   <= next_wr_data;
            fmt_error <= next_fmt_error;
            rx_idle   <= next_pstate == P_IDLE;
        end
    end

    // checksum engine: flash scan plus response byte window
    assign idx1     = resp_idx + 8'h01;
    assign resp_add = resp_valid && win_last != 8'h00 &&
                      idx1 >= win_first && idx1 <= win_last;

    always_comb
    begin
        next_scan      = scan;
        next_mem_addr  = mem_addr;
        next_scan_end  = scan_end;
        next_rd_pend   = 1'b0;
        next_resp_idx  = resp_idx;
        next_win_first = win_first;
        next_win_last  = win_last;
        next_sum_done  = 1'b0;
        // framing bytes never reach this adder
        next_sum = sum + (rd_pend ? {8'h00, mem_rdata} : 16'h0000) +
                   (resp_add ? {8'h00, resp_byte} : 16'h0000);
        if (resp_valid)
        begin
            next_resp_idx = idx1;
            if (win_last != 8'h00 && idx1 == win_last)
            begin
                next_sum_done = 1'b1;
                next_win_last = 8'h00;
            end
        end
        unique case (scan)
            SC_IDLE: next_scan = SC_IDLE;
            SC_RUN:
            begin
                next_rd_pend = 1'b1;
                if (mem_addr == scan_end)
                    next_scan = SC_TAIL;
                else
                    next_mem_addr = mem_addr + 16'h0001;
            end
            SC_TAIL:
            begin
                next_scan     = SC_IDLE;
                next_sum_done = 1'b1;
            end
        endcase
        if (end_ok)
        begin
            next_scan     = SC_RUN;
            next_mem_addr = `HRX_FLASH_LO;
            next_scan_end = `HRX_FLASH_HI;
        end
        if (cmd_start && sums_cmd(cmd_code))
        begin
            next_sum       = `HRX_SUM_RST;
            next_resp_idx  = 8'h00;
            next_win_last  = 8'h00;
            next_scan      = SC_IDLE;
            next_rd_pend   = 1'b0;
            next_mem_addr  = region_lo;
            next_scan_end  = region_hi;
            unique case (cmd_code)
                `HRX_CMD_ERASE:
                begin
                    next_scan = SC_RUN;
                    if (erase_chip)
                    begin
                        next_mem_addr = `HRX_FLASH_LO;
                        next_scan_end = `HRX_FLASH_HI;
                    end
                end
                `HRX_CMD_SUM:
                begin
                    next_scan     = SC_RUN;
                    next_mem_addr = `HRX_FLASH_LO;
                    next_scan_end = `HRX_FLASH_HI;
                end
                `HRX_CMD_READ: next_scan = SC_RUN;
                `HRX_CMD_ID:
                begin
                    next_win_first = `HRX_ID_FIRST;
                    next_win_last  = `HRX_ID_LAST;
                end
                `HRX_CMD_STAT:
                begin
                    next_win_first = `HRX_ST_FIRST;
                    next_win_last  = `HRX_ST_LAST;
                end
                default: next_scan = SC_IDLE; // write waits for the end record
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scan      <= SC_IDLE;
            mem_addr  <= 16'h0000;
            scan_end  <= 16'h0000;
            rd_pend   <= 1'b0;
            sum       <= `HRX_SUM_RST;
            resp_idx  <= 8'h00;
            win_first <= 8'h00;
            win_last  <= 8'h00;
            sum_done  <= 1'b0;
            sum_hi    <= 8'h00;
            sum_lo    <= 8'h00;
        end
        else
        begin
            scan      <= next_scan;
            mem_addr  <= next_mem_addr;
            scan_end  <= next_scan_end;
            rd_pend   <= next_rd_pend;
            sum       <= next_sum;
            resp_idx  <= next_resp_idx;
            win_first <= next_win_first;
            win_last  <= next_win_last;
            sum_done  <= next_sum_done;
            sum_hi    <= next_sum[15:8];
            sum_lo    <= next_sum[7:0];
        end
    end

    a_mark_opens: assert property (@(posedge clk) disable iff (rst)
        (pstate == P_WAIT && rx_ok && rx_data == `HRX_START && !cmd_start)
        |=> pstate == P_LEN)
        else $error("start mark did not open a record");
    a_gap_dropped: assert property (@(posedge clk) disable iff (rst)
        (pstate == P_WAIT && rx_ok && rx_data != `HRX_START && !cmd_start)
        |=> pstate == P_WAIT && !wr_valid)
        else $error("byte between records was not dropped");
    a_rx_err_idle: assert property (@(posedge clk) disable iff (rst)
        (rx_error && !cmd_start && pstate != P_IDLE && pstate != P_DONE)
        |=> pstate == P_IDLE && fmt_error && rx_idle)
        else $error("receive error did not park the receiver");
    a_bad_type: assert property (@(posedge clk) disable iff (rst)
        (pstate == P_TYPE && rx_ok && !cmd_start && rx_data > `HRX_T_EXT)
        |=> fmt_error && pstate == P_IDLE)
        else $error("bad record type accepted");
    a_bad_check: assert property (@(posedge clk) disable iff (rst)
        (pstate == P_CSUM && rx_ok && !cmd_start && (csum + rx_data) != 8'h00)
        |=> fmt_error)
        else $error("record checksum mismatch accepted");
    a_data_write: assert property (@(posedge clk) disable iff (rst)
        (pstate == P_DATA && rx_ok && !cmd_start && rtype == `HRX_T_DATA)
        |=> wr_valid && wr_data == $past(rx_data))
        else $error("data byte not written");
    a_write_scan: assert property (@(posedge clk) disable iff (rst)
        end_ok |=> scan == SC_RUN && mem_addr == `HRX_FLASH_LO)
        else $error("write checksum scan did not start at flash base");
    a_sum_add: assert property (@(posedge clk) disable iff (rst)
        (rd_pend && !resp_add && !cmd_start)
        |=> sum == 16'($past(sum) + {8'h00, $past(mem_rdata)}))
        else $error("flash byte not added into checksum");
    a_sum_clear: assert property (@(posedge clk) disable iff (rst)
        (cmd_start && sums_cmd(cmd_code)) |=> sum == `HRX_SUM_RST)
        else $error("checksum not cleared at command start");
    a_scan_end: assert property (@(posedge clk) disable iff (rst)
        (scan == SC_RUN && mem_addr == scan_end && !cmd_start && !end_ok)
        |=> scan == SC_TAIL ##1 sum_done)
        else $error("scan did not finish at its last address");
endmodule : hrx_receiver_checksum

// File: tb_top.sv
// self-checking bench for the hex record receiver and checksum engine
// assumes hrx_ctrl_model as controller and flash; inputs move 5 ns after clk rises
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0, rst = 1'b1, cmd_start = 1'b0, erase_chip = 1'b0;
    logic        rx_error = 1'b0, resp_valid = 1'b0;
    logic [7:0]  cmd_code = 8'h00, resp_byte = 8'h00;
    logic [15:0] region_lo = 16'h0000, region_hi = 16'h0000, seg = 16'h0000;
    logic [15:0] done_sum = 16'h0000, s16;
    logic [27:0] e_w;
    wire logic   rx_valid, wr_valid, fmt_error, rx_idle, sum_done;
    wire logic [7:0]  rx_data, mem_rdata, wr_data, sum_hi, sum_lo;
    wire logic [15:0] mem_addr;
    wire logic [19:0] wr_addr;
    int          miscompares = 0, num_checks = 0, dones = 0, mark = 0, n, seed;
    logic [7:0]  wmap [int];
    logic [27:0] exp_wr [$];
    logic [7:0]  none [$];

    always #50 clk = ~clk;

    hrx_receiver_checksum uut (.clk(clk), .rst(rst), .cmd_start(cmd_start),
        .cmd_code(cmd_code), .erase_chip(erase_chip), .region_lo(region_lo),
        .region_hi(region_hi), .rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error),
        .resp_valid(resp_valid), .resp_byte(resp_byte), .mem_rdata(mem_rdata),
        .mem_addr(mem_addr), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
        .fmt_error(fmt_error), .rx_idle(rx_idle), .sum_done(sum_done), .sum_hi(sum_hi),
        .sum_lo(sum_lo));

    hrx_ctrl_model p (.clk(clk), .mem_addr(mem_addr), .wr_valid(wr_valid),
        .wr_addr(wr_addr), .wr_data(wr_data), .rx_valid(rx_valid), .rx_data(rx_data),
        .mem_rdata(mem_rdata));

    task automatic check(input logic [19:0] seen, input logic [19:0] exp, input string what);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    // every write must match the next one the model predicted, in order
    always @(posedge clk)
    begin
        if (wr_valid === 1'b1)
        begin
            if (exp_wr.size() == 0)
                check(20'h00001, 20'h00000, "write while none expected");
            else
            begin
                e_w = exp_wr.pop_front();
                check(wr_addr, e_w[27:8], "write address");
                check({12'h000, wr_data}, {12'h000, e_w[7:0]}, "write data");
            end
        end
        if (sum_done === 1'b1)
        begin
            done_sum = {sum_hi, sum_lo};
            dones++;
        end
    end

    function automatic logic [7:0] fl(input int a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : fl

    // 16-bit wrapping byte sum over the modelled flash contents
    function automatic logic [15:0] ref_sum(input int lo, input int hi);
        logic [15:0] s;
        s = 16'h0000;
        for (int a = lo; a <= hi; a++)
            s += wmap.exists(a) ? wmap[a] : fl(a);
        return s;
    endfunction : ref_sum

    task automatic pulse_cmd(input logic [7:0] c, input logic ch, input logic [15:0] lo,
                             input logic [15:0] hi);
        @(posedge clk);
        #5;
        cmd_code   = c;
        erase_chip = ch;
        region_lo  = lo;
        region_hi  = hi;
        cmd_start  = 1'b1;
        mark       = dones;
        @(posedge clk);
        #5;
        cmd_start = 1'b0;
    endtask : pulse_cmd

    task automatic wait_done(input int lim, input logic [15:0] exp);
        n = 0;
        while (dones == mark && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        check(20'(dones - mark), 20'h00001, "completion count");
        check({4'h0, done_sum}, {4'h0, exp}, "checksum");
    endtask : wait_done

    task automatic send_rec(input logic [7:0] len, input logic [15:0] off,
                            input logic [7:0] typ, input logic [7:0] d [$], input logic bad);
        logic [7:0] s;
        s = len + off[15:8] + off[7:0] + typ;
        foreach (d[i]) s += d[i];
        p.send_byte(8'h3a);
        p.send_byte(len);
        p.send_byte(off[15:8]);
        p.send_byte(off[7:0]);
        p.send_byte(typ);
        foreach (d[i]) p.send_byte(d[i]);
        p.send_byte((8'h00 - s) ^ {7'h00, bad});
    endtask : send_rec

    task automatic send_data(input logic [15:0] off, input int cnt);
        logic [7:0]  d [$];
        logic [19:0] a;
        for (int i = 0; i < cnt; i++)
        begin
            d.push_back(8'($urandom));
            a = {seg, 4'h0} + 20'(off) + 20'(i);
            exp_wr.push_back({a, d[i]});
            wmap[int'(a[15:0])] = d[i];
        end
        send_rec(8'(cnt), off, 8'h00, d, 1'b0);
    endtask : send_data

    initial
    begin
        #9_800_000;
        miscompares++;
        end_of_test();
    end

    initial
    begin
        seed = $urandom(80935);
        for (int a = 0; a < 65536; a++) p.mem[a] = fl(a);
        repeat (12) @(posedge clk);
        #5;
        rst = 1'b0;
        #1;
        check({19'h0, rx_idle}, 20'h1, "idle after reset");
        check({19'h0, fmt_error}, 20'h0, "error after reset");
        // sector erase then read over a short region
        for (int k = 0; k < 2; k++)
        begin
            pulse_cmd(k ? 8'h40 : 8'hf0, 1'b0, 16'h1234, 16'h1243 + 16'(k));
            wait_done(40, ref_sum(32'h1234, 32'h1243 + k));
        end
        // id and status responses, only a fixed byte window counts
        for (int k = 0; k < 2; k++)
        begin
            pulse_cmd(k ? 8'hc3 : 8'hc0, 1'b0, 16'h0000, 16'h0000);
            s16 = 16'h0000;
            for (int i = 1; i <= (k ? 12 : 18); i++)
            begin
                @(posedge clk);
                #5;
                resp_valid = 1'b1;
                resp_byte  = 8'($urandom);
                if (i >= 9) s16 += {8'h00, resp_byte};
                @(posedge clk);
                #5;
                resp_valid = 1'b0;
            end
            wait_done(4, s16);
        end
        // whole-array scans: watch the address walk, then cut short by reset
        for (int k = 0; k < 2; k++)
        begin
            pulse_cmd(k ? 8'h90 : 8'hf0, 1'b1, 16'h0000, 16'h0000);
            n = 0;
            while (mem_addr !== 16'h1000 && n < 4)
            begin
                @(posedge clk);
                #1;
                n++;
            end
            for (int i = 1; i <= 8; i++)
            begin
                @(posedge clk);
                #1;
                check({4'h0, mem_addr}, 20'h01000 + 20'(i), "scan address");
            end
            #4;
            rst = 1'b1;
            repeat (2) @(posedge clk);
            #5;
            rst = 1'b0;
            repeat (3) @(posedge clk);
            #1;
            check(20'(dones - mark), 20'h00000, "completion after cut scan");
            check({4'h0, sum_hi, sum_lo}, 20'h00000, "checksum after reset");
        end
        // full write: junk before and between records, segment, two data records
        pulse_cmd(8'h30, 1'b0, 16'h0000, 16'h0000);
        check({19'h0, rx_idle}, 20'h0, "receiver awake");
        repeat (3) p.send_byte(8'($urandom % 58));
        seg = 16'h0100;
        send_rec(8'h02, 16'h0000, 8'h02, '{8'h01, 8'h00}, 1'b0);
        send_data(16'h0010, 4);
        p.send_byte(8'hc5);
        send_data(16'he000, 3);
        repeat (30000) @(posedge clk);
        mark = dones;
        send_rec(8'h00, 16'h0000, 8'h01, none, 1'b0);
        wait_done(62000, ref_sum(32'h1000, 32'hffff));
        repeat (2) @(posedge clk);
        #1;
        check({19'h0, rx_idle}, 20'h1, "idle after end record");
        check(20'(exp_wr.size()), 20'h0, "writes left over");
        // each broken record parks the receiver and blocks later data
        for (int k = 0; k < 8; k++)
        begin
            pulse_cmd(8'h30, 1'b0, 16'h0000, 16'h0000);
            check({19'h0, fmt_error}, 20'h0, "error cleared by write");
            case (k)
                0: send_rec(8'h01, 16'h0010, 8'h03, '{8'h11}, 1'b0);
                1: send_rec(8'h02, 16'h0000, 8'h02, '{8'h01, 8'h00}, 1'b1);
                2: send_rec(8'h03, 16'h0000, 8'h02, '{8'h01, 8'h00, 8'h00}, 1'b0);
                3: send_rec(8'h01, 16'h0000, 8'h01, '{8'h00}, 1'b0);
                4: send_rec(8'h02, 16'h0001, 8'h02, '{8'h01, 8'h00}, 1'b0);
                5:
                begin
                    send_rec(8'h02, 16'h0000, 8'h02, '{8'h20, 8'h01}, 1'b0);
                    send_rec(8'h01, 16'h0010, 8'h00, '{8'h11}, 1'b0);
                end
                6: send_rec(8'h00, 16'h0010, 8'h00, none, 1'b0);
                default:
                begin
                    p.send_byte(8'h3a);
                    p.send_byte(8'h01);
                    @(posedge clk);
                    #5;
                    rx_error = 1'b1;
                    @(posedge clk);
                    #5;
                    rx_error = 1'b0;
                end
            endcase
            repeat (2) @(posedge clk);
            #1;
            check({19'h0, fmt_error}, 20'h1, "format error raised");
            check({19'h0, rx_idle}, 20'h1, "parked after error");
            send_rec(8'h01, 16'h0020, 8'h00, '{8'h77}, 1'b0);
        end
        repeat (4) @(posedge clk);
        end_of_test();
    end
endmodule : tb_top
